/* ser_cfg_top.sv */
`timescale 1ns/1ps
module ser_cfg_top (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        CLK_EN_I,
  input  wire logic        POWER_DOWN_N_I,
  input  wire logic        RATE_RANGE_SELECT_I,
  input  wire logic [1:0]  ADDR_STRAP_LOW_I,
  input  wire logic [1:0]  ADDR_STRAP_HIGH_I,
  input  wire logic        LANE_COUNT_SELECT_I,
  input  wire logic        CONTROL_SIDE_SELECT_I,
  input  wire logic        CONTROL_LINK_MODE_SELECT_I,
  input  wire logic        AUTOSTART_N_I,
  input  wire logic        PIXEL_CLOCK_IN_I,
  input  wire logic [27:0] LANE_BITS_I,
  input  wire logic        AUDIO_DATA_OR_CTRL0_I,
  input  wire logic        AUDIO_SCK_I,
  input  wire logic        AUDIO_WS_I,
  input  wire logic        AUX_CTRL_ONE_I,
  input  wire logic        AUX_CTRL_TWO_I,
  input  wire logic        REG_WE_I,
  input  wire logic        REG_RE_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  output logic      [7:0]  REG_RDATA_O,
  output logic             REG_ACK_O,
  output logic             ACTIVE_O,
  output logic             RATE_LOW_RANGE_O,
  output logic             FOUR_LANE_O,
  output logic             REMOTE_CONTROLLER_O,
  output logic             BYPASS_MODE_O,
  output logic             LINK_START_O,
  output logic             AUTO_RANGE_O,
  output logic             AUDIO_ENABLED_O,
  output logic [31:0]      FRAME_O,
  output logic [31:0]      ENCRYPT_MASK_O,
  output logic             FRAME_VALID_O
);
  // Strap vector: rate, addr_low[1:0], addr_high[1:0], lane, side, mode, autostart_n.
  localparam int NS = 9;
  logic [NS-1:0] strap_raw;
  logic [NS-1:0] s1_r, s2_r, s3_r, strap_r;
  logic [2:0]    pd1_r;
  logic          pd2_r, pd3_r, pd_r;
  logic          run_r, capture_pend_r;
  logic [7:0]    addr_first_r, addr_second_r, ctrl_r;
  logic [2:0]    pclk_sync_r;
  logic          pclk_prev_r;
  logic          pclk_rise;
  logic [3:0]    aux1_sync_r, aux2_sync_r, sd_sync_r;
  logic [7:0]    dev_addr_nxt;
  logic [NS-1:0] strap_now;
  logic          enc_on, audio_on;
  logic [31:0]   frame_nxt, mask_nxt;

  assign strap_raw = {RATE_RANGE_SELECT_I, ADDR_STRAP_LOW_I, ADDR_STRAP_HIGH_I,
                      LANE_COUNT_SELECT_I, CONTROL_SIDE_SELECT_I,
                      CONTROL_LINK_MODE_SELECT_I, AUTOSTART_N_I};

  // Three stages; a level counts once stages two and three agree.
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (CLK_EN_I) begin
      s1_r <= strap_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pd1_r <= '0;
      pd2_r <= 1'b0;
      pd3_r <= 1'b0;
      pd_r  <= 1'b0;
    end else if (CLK_EN_I) begin
      pd1_r[0] <= POWER_DOWN_N_I;
      pd2_r    <= pd1_r[0];
      pd3_r    <= pd2_r;
      if (pd2_r == pd3_r) begin
        pd_r <= pd3_r;
      end
    end
  end

  // Per-bit agreement filter; a bit that still disagrees keeps its old value.
  always_comb begin
    for (int i = 0; i < NS; i++) begin
      strap_now[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : strap_r[i];
    end
  end

  // Capture waits one cycle after power-down release so the filter has settled.
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      run_r          <= 1'b0;
      capture_pend_r <= 1'b1;
      strap_r        <= '0;
    end else if (CLK_EN_I) begin
      if (!pd_r) begin
        run_r          <= 1'b0;
        capture_pend_r <= 1'b1;
      end else if (capture_pend_r) begin
        strap_r        <= strap_now;
        capture_pend_r <= 1'b0;
        run_r          <= 1'b1;
      end
    end
  end

  function automatic logic [7:0] decode_addr(input logic [1:0] hi, input logic [1:0] lo);
    logic [7:0] a;
    a = 8'h00;
    case (hi)
      ser_cfg_pkg::LVL_LOW:  a[7:6] = 2'b10;
      ser_cfg_pkg::LVL_HIGH: a[7:6] = 2'b11;
      default:               a[7:6] = 2'b01;
    endcase
    case (lo)
      ser_cfg_pkg::LVL_LOW:  a[3:2] = 2'b00;
      ser_cfg_pkg::LVL_HIGH: a[3:2] = 2'b01;
      default:               a[3:2] = 2'b10;
    endcase
    return a;
  endfunction

  assign dev_addr_nxt = decode_addr(strap_now[5:4], strap_now[7:6]);

  // Registers; a fresh strap capture reloads the addresses.
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      addr_first_r  <= ser_cfg_pkg::SER_ADDR_BASE_LL;
      addr_second_r <= ser_cfg_pkg::SER_ADDR_BASE_LL | ser_cfg_pkg::DES_ADDR_OFFSET;
      ctrl_r        <= ser_cfg_pkg::CTRL_RESET;
    end else if (CLK_EN_I) begin
      if (pd_r && capture_pend_r) begin
        addr_first_r  <= dev_addr_nxt;
        addr_second_r <= dev_addr_nxt | ser_cfg_pkg::DES_ADDR_OFFSET;
      end else if (REG_WE_I) begin
        case (REG_ADDR_I)
          ser_cfg_pkg::OFS_DEV_ADDR_FIRST:  addr_first_r  <= REG_WDATA_I;
          ser_cfg_pkg::OFS_DEV_ADDR_SECOND: addr_second_r <= REG_WDATA_I;
          ser_cfg_pkg::OFS_LINK_CONTROL:    ctrl_r        <= REG_WDATA_I;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      REG_RDATA_O <= 8'h00;
      REG_ACK_O   <= 1'b0;
    end else if (CLK_EN_I) begin
      REG_ACK_O <= REG_WE_I | REG_RE_I;
      if (REG_RE_I) begin
        case (REG_ADDR_I)
          ser_cfg_pkg::OFS_DEV_ADDR_FIRST:  REG_RDATA_O <= addr_first_r;
          ser_cfg_pkg::OFS_DEV_ADDR_SECOND: REG_RDATA_O <= addr_second_r;
          ser_cfg_pkg::OFS_LINK_STATUS:     REG_RDATA_O <= {run_r, strap_r[8], strap_r[3+:0+1],
                                                            strap_r[3], strap_r[2],
                                                            strap_r[1], strap_r[0], pd_r};
          ser_cfg_pkg::OFS_LINK_CONTROL:    REG_RDATA_O <= ctrl_r;
          default:                          REG_RDATA_O <= 8'h00;
        endcase
      end
    end
  end

  assign ACTIVE_O            = run_r;
  assign RATE_LOW_RANGE_O    = strap_r[8];
  assign FOUR_LANE_O         = strap_r[3];
  assign REMOTE_CONTROLLER_O = strap_r[2];
  assign BYPASS_MODE_O       = strap_r[1];
  assign LINK_START_O        = run_r & ~strap_r[0];
  assign AUTO_RANGE_O        = run_r & ~strap_r[0];
  assign enc_on              = ctrl_r[ser_cfg_pkg::CTRL_ENC_BIT];
  assign audio_on            = ctrl_r[ser_cfg_pkg::CTRL_AUDIO_BIT];
  assign AUDIO_ENABLED_O     = audio_on;

  // Pixel clock edge detection by oversampling with the system clock.
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pclk_sync_r <= '0;
      pclk_prev_r <= 1'b0;
    end else if (CLK_EN_I) begin
      pclk_sync_r <= {pclk_sync_r[1:0], PIXEL_CLOCK_IN_I};
      if (pclk_sync_r[1] == pclk_sync_r[2]) begin
        pclk_prev_r <= pclk_sync_r[2];
      end
    end
  end
  assign pclk_rise = (pclk_sync_r[1] == pclk_sync_r[2]) & pclk_sync_r[2] & ~pclk_prev_r;

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      aux1_sync_r <= '0;
      aux2_sync_r <= '0;
      sd_sync_r   <= '0;
    end else if (CLK_EN_I) begin
      aux1_sync_r <= {aux1_sync_r[2:0], AUX_CTRL_ONE_I};
      aux2_sync_r <= {aux2_sync_r[2:0], AUX_CTRL_TWO_I};
      sd_sync_r   <= {sd_sync_r[2:0], AUDIO_DATA_OR_CTRL0_I};
    end
  end

  // Lane bits are sampled straight on the pixel clock rising edge; the source holds
  // them stable around that edge, and the edge is seen a few cycles late.
  always_comb begin
    frame_nxt = 32'h0;
    mask_nxt  = 32'h0;
    if (strap_r[3]) begin
      frame_nxt[ser_cfg_pkg::LANE4_BITS-1:0] = LANE_BITS_I;
      frame_nxt[27] = aux1_sync_r[2];
      frame_nxt[28] = aux2_sync_r[2];
    end else begin
      frame_nxt[ser_cfg_pkg::LANE3_BITS-1:0] = LANE_BITS_I[ser_cfg_pkg::LANE3_BITS-1:0];
    end
    frame_nxt[29] = sd_sync_r[2];
    frame_nxt[30] = AUDIO_SCK_I & audio_on;
    frame_nxt[31] = AUDIO_WS_I & audio_on;
    if (enc_on) begin
      mask_nxt[ser_cfg_pkg::COLOUR_BITS-1:0] = '1;
      if (strap_r[3]) begin
        mask_nxt[ser_cfg_pkg::EXTRA_COLOUR_HI:ser_cfg_pkg::EXTRA_COLOUR_LO] = '1;
      end
      mask_nxt[29] = audio_on;
      mask_nxt[31:30] = {2{audio_on}};
    end
    mask_nxt[28:27] = 2'b00;
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      FRAME_O        <= 32'h0;
      ENCRYPT_MASK_O <= 32'h0;
      FRAME_VALID_O  <= 1'b0;
    end else if (CLK_EN_I) begin
      FRAME_VALID_O <= run_r & pclk_rise;
      if (run_r & pclk_rise) begin
        FRAME_O        <= frame_nxt;
        ENCRYPT_MASK_O <= mask_nxt;
      end
    end
  end

  // The control UART divider limits sit in the package for the link block.
endmodule

/* ser_cfg_pkg.sv */
package ser_cfg_pkg;
  localparam logic [7:0] OFS_DEV_ADDR_FIRST  = 8'h00;
  localparam logic [7:0] OFS_DEV_ADDR_SECOND = 8'h01;
  localparam logic [7:0] OFS_LINK_STATUS     = 8'h02;
  localparam logic [7:0] OFS_LINK_CONTROL    = 8'h03;
  localparam int CTRL_ENC_BIT   = 0;
  localparam int CTRL_AUDIO_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h02;
  localparam int LANE3_BITS = 21;
  localparam int LANE4_BITS = 28;
  localparam int COLOUR_BITS = 18;
  localparam int EXTRA_COLOUR_LO = 21;
  localparam int EXTRA_COLOUR_HI = 26;
  localparam int SYS_CLK_KHZ = 250000;
  localparam int UART_MIN_BPS = 9600;
  localparam int UART_MAX_BPS = 1000000;
  localparam logic [15:0] UART_DIV_RESET = 16'd250;
  localparam logic [15:0] UART_DIV_MIN = 16'(SYS_CLK_KHZ * 1000 / UART_MAX_BPS);
  localparam logic [15:0] UART_DIV_MAX = 16'(SYS_CLK_KHZ * 1000 / UART_MIN_BPS);
  localparam int AUDIO_WORD_MIN = 4;
  localparam int AUDIO_WORD_MAX = 32;
  localparam logic [7:0] SER_ADDR_BASE_LL = 8'h80;
  localparam logic [1:0] LVL_LOW  = 2'b00;
  localparam logic [1:0] LVL_HIGH = 2'b01;
  localparam logic [1:0] LVL_OPEN = 2'b10;
  localparam logic [7:0] DES_ADDR_OFFSET = 8'h10;
endpackage

/* ser_cfg_properties.sv */
`timescale 1ns/1ps
module ser_cfg_properties (
  input wire logic        SYS_CLK_I,
  input wire logic        RESETN_I,
  input wire logic        POWER_DOWN_N_I,
  input wire logic        REG_RE_I,
  input wire logic        REG_WE_I,
  input wire logic        REG_ACK_O,
  input wire logic        ACTIVE_O,
  input wire logic        RATE_LOW_RANGE_O,
  input wire logic        FOUR_LANE_O,
  input wire logic        LINK_START_O,
  input wire logic        AUTO_RANGE_O,
  input wire logic        AUDIO_ENABLED_O,
  input wire logic [31:0] FRAME_O,
  input wire logic [31:0] ENCRYPT_MASK_O,
  input wire logic        FRAME_VALID_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);
  a_read_ack: assert property (REG_RE_I |=> REG_ACK_O) else $error("no ack");
  a_ack_idle: assert property (
    !(REG_RE_I || REG_WE_I) |=> !REG_ACK_O) else $error("stray ack");
  a_rate_hold: assert property (
    ACTIVE_O && $past(ACTIVE_O) && $past(ACTIVE_O, 2) |-> $stable(RATE_LOW_RANGE_O))
    else $error("rate moved");
  a_pd_enter: assert property (
    $fell(POWER_DOWN_N_I) |-> ##[1:6] !ACTIVE_O) else $error("still active");
  a_link_start: assert property (
    LINK_START_O |-> ACTIVE_O && AUTO_RANGE_O) else $error("bad start");
  a_aux_plain: assert property (
    FRAME_VALID_O |-> ENCRYPT_MASK_O[28:27] == 2'b00) else $error("aux encrypted");
  a_ctrl0_plain: assert property (
    FRAME_VALID_O && !AUDIO_ENABLED_O |-> !ENCRYPT_MASK_O[29]) else $error("ctrl0 encrypted");
  a_aux_ignored: assert property (
    FRAME_VALID_O && !FOUR_LANE_O |-> FRAME_O[28:27] == 2'b00) else $error("aux used");
  a_valid_pulse: assert property (FRAME_VALID_O |=> !FRAME_VALID_O) else $error("long valid");
  c_four_enc: cover property (FRAME_VALID_O && FOUR_LANE_O && ENCRYPT_MASK_O[0]);
  c_wake: cover property ($rose(ACTIVE_O));
  c_ack: cover property (REG_ACK_O);
endmodule

/* vid_src.sv */
`timescale 1ns/1ps
module vid_src (
  input  wire logic        en_i,
  input  wire logic        slow_i,
  output logic             pclk_o,
  output logic [32:0]      bits_o
);
  int half;
  // Bits move on the falling edge only; while idle they churn so no stale value survives.
  initial begin
    pclk_o = 1'b0;
    forever begin
      bits_o = 33'({$urandom, $urandom});
      if (en_i) begin
        half = slow_i ? 48 : 24;
        #(half) pclk_o = 1'b1;
        #(half) pclk_o = 1'b0;
      end else begin
        #1;
      end
    end
  end
endmodule

/* serializer_strap_and_lane_mapping_tb.sv */
`timescale 1ns/1ps
module serializer_strap_and_lane_mapping_tb;
  logic clk, rst_n, pd_n, rate, lane, side, mode, aut_n, we, re, en, ack, fv, act, pclk;
  logic r_o, f_o, s_o, m_o, l_o, u_o, a_o;
  logic [1:0] alo, ahi;
  logic [7:0] adr, wd, rd, ctrl, wr_v;
  logic [32:0] b;
  logic [31:0] fr, mk, m_e;
  logic [95:0] fq[$];
  logic [95:0] e96;
  logic [8:0] rq[$];
  logic [8:0] e9;
  int fails, checks, k;
  ser_cfg_top DUT (.SYS_CLK_I(clk), .RESETN_I(rst_n), .CLK_EN_I(1'b1), .POWER_DOWN_N_I(pd_n),
    .RATE_RANGE_SELECT_I(rate), .ADDR_STRAP_LOW_I(alo), .ADDR_STRAP_HIGH_I(ahi),
    .LANE_COUNT_SELECT_I(lane), .CONTROL_SIDE_SELECT_I(side),
    .CONTROL_LINK_MODE_SELECT_I(mode), .AUTOSTART_N_I(aut_n), .PIXEL_CLOCK_IN_I(pclk),
    .LANE_BITS_I(b[32:5]), .AUDIO_DATA_OR_CTRL0_I(b[4]), .AUDIO_SCK_I(b[3]),
    .AUDIO_WS_I(b[2]), .AUX_CTRL_ONE_I(b[1]), .AUX_CTRL_TWO_I(b[0]), .REG_WE_I(we),
    .REG_RE_I(re), .REG_ADDR_I(adr), .REG_WDATA_I(wd), .REG_RDATA_O(rd), .REG_ACK_O(ack),
    .ACTIVE_O(act), .RATE_LOW_RANGE_O(r_o), .FOUR_LANE_O(f_o), .REMOTE_CONTROLLER_O(s_o),
    .BYPASS_MODE_O(m_o), .LINK_START_O(l_o), .AUTO_RANGE_O(u_o), .AUDIO_ENABLED_O(a_o),
    .FRAME_O(fr), .ENCRYPT_MASK_O(mk), .FRAME_VALID_O(fv));
  vid_src SRC (.en_i(en), .slow_i(rate), .pclk_o(pclk), .bits_o(b));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [7:0] ser_addr(input int h, input int l);
    return (h == 0 ? 8'h80 : h == 1 ? 8'hc0 : 8'h40) + 8'(4 * l);
  endfunction
  function automatic logic [1:0] lvl(input int v);
    return v == 2 ? 2'b10 : 2'(v);
  endfunction
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    we = w;
    re = !w;
    adr = a;
    wd = d;
    rq.push_back({!w, d});
    @(negedge clk);
    we = 1'b0;
    re = 1'b0;
  endtask
  task automatic wait_act();
    for (k = 0; k < 60 && act !== 1'b1; k++) @(negedge clk);
    if (act !== 1'b1) begin
      fails++;
      end_sim();
    end
  endtask
  task automatic pd_exit(input logic [8:0] s);
    @(negedge clk);
    pd_n = 1'b0;
    repeat (8) @(negedge clk);
    {rate, lane, side, mode, aut_n, ahi, alo} = s;
    // Straps settle well before release so all three synchroniser stages agree by capture time.
    repeat (4) @(negedge clk);
    pd_n = 1'b1;
    wait_act();
    repeat (3) @(negedge clk);
    {rate, lane, side, mode, aut_n} = ~s[8:4];
    repeat (6) @(negedge clk);
    chk("straps", 32'({r_o, f_o, s_o, m_o, l_o}), 32'({s[8:5], !s[4]}));
    {rate, lane, side, mode, aut_n} = s[8:4];
  endtask
  always @(posedge pclk) begin
    m_e = lane ? 32'h3fffffff : 32'h201fffff;
    fq.push_back({m_e, m_e & {2'b00, b[4], b[0], b[1], b[31:5]},
                  m_e & (ctrl[0] ? {2'b00, ctrl[1], 2'b00, {6{lane}}, 21'h3ffff} : 32'h0)});
  end
  always @(negedge clk) begin
    if (ack === 1'b1 && rq.size() == 0) chk("ack", 32'd1, 32'd0);
    else if (ack === 1'b1) begin
      e9 = rq.pop_front();
      if (e9[8]) chk("rdata", 32'(rd), 32'(e9[7:0]));
    end
    if (fv === 1'b1 && fq.size() == 0) chk("valid", 32'd1, 32'd0);
    else if (fv === 1'b1) begin
      e96 = fq.pop_front();
      chk("frame", fr & e96[95:64], e96[63:32]);
      chk("mask", mk & e96[95:64], e96[31:0]);
    end
  end
  initial begin
    clk = 1'b0;
    #1;
    forever #2 clk = ~clk;
  end
  initial begin
    {rst_n, we, re, en, rate, lane, side, mode, alo, ahi, adr, wd} = '0;
    {pd_n, aut_n} = 2'b11;
    ctrl = ser_cfg_pkg::CTRL_RESET;
    k = $urandom(32'h13538968);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    wait_act();
    acc(1'b0, ser_cfg_pkg::OFS_LINK_CONTROL, ser_cfg_pkg::CTRL_RESET);
    acc(1'b0, 8'h7f, 8'h00);
    for (int i = 0; i < 9; i++) begin
      pd_exit({5'($urandom), lvl(i / 3), lvl(i % 3)});
      acc(1'b0, ser_cfg_pkg::OFS_DEV_ADDR_FIRST, ser_addr(i / 3, i % 3));
      acc(1'b0, ser_cfg_pkg::OFS_DEV_ADDR_SECOND, ser_addr(i / 3, i % 3) + 8'h10);
      wr_v = 8'($urandom);
      acc(1'b1, ser_cfg_pkg::OFS_DEV_ADDR_FIRST, wr_v);
      acc(1'b0, ser_cfg_pkg::OFS_DEV_ADDR_FIRST, wr_v);
    end
    for (int j = 0; j < 8; j++) begin
      pd_exit({1'(j >> 1), 1'(j), 3'($urandom), 4'h0});
      ctrl = 8'(j >> 1) & 8'h03;
      acc(1'b1, ser_cfg_pkg::OFS_LINK_CONTROL, ctrl);
      acc(1'b0, ser_cfg_pkg::OFS_LINK_CONTROL, ctrl);
      en = 1'b1;
      // A bounded wait of about a dozen slow pixel clock periods.
      repeat (320) @(negedge clk);
      en = 1'b0;
      repeat (40) @(negedge clk);
      chk("pending", 32'(fq.size()), 32'd0);
    end
    end_sim();
  end
endmodule
bind ser_cfg_top ser_cfg_properties PROPS (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I),
  .POWER_DOWN_N_I(POWER_DOWN_N_I), .REG_RE_I(REG_RE_I), .REG_WE_I(REG_WE_I),
  .REG_ACK_O(REG_ACK_O), .ACTIVE_O(ACTIVE_O), .RATE_LOW_RANGE_O(RATE_LOW_RANGE_O),
  .FOUR_LANE_O(FOUR_LANE_O), .LINK_START_O(LINK_START_O), .AUTO_RANGE_O(AUTO_RANGE_O),
  .AUDIO_ENABLED_O(AUDIO_ENABLED_O), .FRAME_O(FRAME_O), .ENCRYPT_MASK_O(ENCRYPT_MASK_O),
  .FRAME_VALID_O(FRAME_VALID_O));
